// ### rtl/chtu_pkg.sv
// Purpose: Constants and types of the CPU hardware trap unit.
// Assumes: One clock, synchronous active-low reset.
// Notes: Trap sources are indexed 0..8; flag bits live in trap_flag_reg.
//
// Behaviour
// - Trap branches at once, unmasked, to its vector
// - Each trap sets its own flag bit
// - Trap preempts unless equal- or higher-priority trap in service
// - Trap service blocks standard and event-transfer interrupts
// - Stack access checks pointer against both limits
// - Stack of up to 32K words, anywhere
// - Class A traps use separate vectors 08h-20h
// - Class B traps share vector 28h, number 0Ah
// - Vector segment comes from segment register
// - Spacing field sets vector distance, default 4
package chtu_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned SEG_W = 8;
    localparam int unsigned FLAG_W = 16;
    localparam int unsigned NSRC = 9;
    localparam int unsigned STACK_WORDS = 32768;

    // ----------------------------------------------------------------
    // Source indices
    // ----------------------------------------------------------------
    localparam int unsigned SRC_REQ0 = 0;
    localparam int unsigned SRC_OVF = 1;
    localparam int unsigned SRC_UNF = 2;
    localparam int unsigned SRC_SBRK = 3;
    localparam int unsigned SRC_REQ1 = 4;
    localparam int unsigned SRC_UNDEF = 5;
    localparam int unsigned SRC_ACCERR = 6;
    localparam int unsigned SRC_PROT = 7;
    localparam int unsigned SRC_ILLWORD = 8;

    // ----------------------------------------------------------------
    // Flag bit positions in trap_flag_reg
    // ----------------------------------------------------------------
    localparam int unsigned FLG_REQ0 = 15;
    localparam int unsigned FLG_OVF = 14;
    localparam int unsigned FLG_UNF = 13;
    localparam int unsigned FLG_SBRK = 12;
    localparam int unsigned FLG_REQ1 = 7;
    localparam int unsigned FLG_UNDEF = 3;
    localparam int unsigned FLG_ACCERR = 2;
    localparam int unsigned FLG_PROT = 1;
    localparam int unsigned FLG_ILLWORD = 0;
    localparam logic [FLAG_W-1:0] FLAG_RST = 16'h0000;

    // ----------------------------------------------------------------
    // Trap numbers and priority levels
    // ----------------------------------------------------------------
    localparam logic [6:0] NUM_REQ0 = 7'h02;
    localparam logic [6:0] NUM_OVF = 7'h04;
    localparam logic [6:0] NUM_UNF = 7'h06;
    localparam logic [6:0] NUM_SBRK = 7'h08;
    localparam logic [6:0] NUM_CLASSB = 7'h0a;
    localparam logic [1:0] LVL_NONE = 2'h0;
    localparam logic [1:0] LVL_REQ0 = 2'h3;
    localparam logic [1:0] LVL_STK = 2'h2;
    localparam logic [1:0] LVL_LOW = 2'h1;
    localparam logic [1:0] SPACING_RST = 2'h0;

    typedef enum logic [1:0] {
        CHTU_IDLE = 2'b00,
        CHTU_TAKE = 2'b01,
        CHTU_SERVICE = 2'b11
    } chtu_state_e;

endpackage : chtu_pkg

// ### rtl/chtu_stack_check.sv
// Purpose: Stack limit comparator of the trap unit.
// Assumes: Stack grows downward; upper limit is the lowest legal address.
// Notes: Results are one-cycle pulses one cycle after the access.
module chtu_stack_check (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic stack_access,
    input wire logic [chtu_pkg::ADDR_W-1:0] stack_ptr,
    input wire logic [chtu_pkg::ADDR_W-1:0] stack_upper_limit,
    input wire logic [chtu_pkg::ADDR_W-1:0] stack_lower_limit,
    output logic overflow_pulse,
    output logic underflow_pulse
);

    logic ovf_q;
    logic ovf_d;
    logic unf_q;
    logic unf_d;

    // ----------------------------------------------------------------
    // Compare on every access
    // ----------------------------------------------------------------
    always_comb
    begin
        ovf_d = stack_access && (stack_ptr < stack_upper_limit);
        unf_d = stack_access && (stack_ptr > stack_lower_limit);
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            ovf_q <= 1'b0;
            unf_q <= 1'b0;
        end
        else
        begin
            ovf_q <= ovf_d;
            unf_q <= unf_d;
        end
    end

    assign overflow_pulse = ovf_q;
    assign underflow_pulse = unf_q;

    a_ovf_detect: assert property (@(posedge sys_clk) disable iff (!rst_n)
        stack_access && (stack_ptr < stack_upper_limit) |=> overflow_pulse)
        else $error("Overflow not flagged");
    a_unf_detect: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !(stack_access && (stack_ptr > stack_lower_limit)) |=> !underflow_pulse)
        else $error("Spurious underflow");

endmodule : chtu_stack_check

// ### rtl/chtu_trap_unit.sv
// Purpose: Hardware trap unit: flags, priority, vector and service tracking.
// Assumes: Trap triggers are one-cycle pulses from the pipeline clock domain.
// Notes: trap_return ends the innermost trap service.
module chtu_trap_unit (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sys_req0_trig,
    input wire logic soft_break_trig,
    input wire logic sys_req1_trig,
    input wire logic undef_opcode_trig,
    input wire logic mem_access_err_trig,
    input wire logic prot_instr_trig,
    input wire logic illegal_word_trig,
    input wire logic stack_access,
    input wire logic [chtu_pkg::ADDR_W-1:0] stack_ptr,
    input wire logic [chtu_pkg::ADDR_W-1:0] stack_upper_limit,
    input wire logic [chtu_pkg::ADDR_W-1:0] stack_lower_limit,
    input wire logic [chtu_pkg::SEG_W-1:0] vector_segment_reg,
    input wire logic [1:0] vector_spacing_field,
    input wire logic [chtu_pkg::FLAG_W-1:0] trap_flag_clr,
    input wire logic trap_return,
    output logic [chtu_pkg::FLAG_W-1:0] trap_flag_reg,
    output logic trap_branch,
    output logic [chtu_pkg::SEG_W+chtu_pkg::ADDR_W-1:0] trap_vector_addr,
    output logic [6:0] trap_number,
    output logic trap_active,
    output logic [1:0] trap_level,
    output logic intr_block
);

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    function automatic logic [1:0] lvl_of(input logic [3:0] idx);
        case (idx)
            4'h0: lvl_of = chtu_pkg::LVL_REQ0;
            4'h1: lvl_of = chtu_pkg::LVL_STK;
            4'h2: lvl_of = chtu_pkg::LVL_STK;
            default: lvl_of = chtu_pkg::LVL_LOW;
        endcase
    endfunction : lvl_of

    function automatic logic [6:0] num_of(input logic [3:0] idx);
        case (idx)
            4'h0: num_of = chtu_pkg::NUM_REQ0;
            4'h1: num_of = chtu_pkg::NUM_OVF;
            4'h2: num_of = chtu_pkg::NUM_UNF;
            4'h3: num_of = chtu_pkg::NUM_SBRK;
            default: num_of = chtu_pkg::NUM_CLASSB;
        endcase
    endfunction : num_of

    // ----------------------------------------------------------------
    // Stack limit check
    // ----------------------------------------------------------------
    logic ovf_pulse;
    logic unf_pulse;

    chtu_stack_check u_stack_check (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .stack_access(stack_access),
        .stack_ptr(stack_ptr),
        .stack_upper_limit(stack_upper_limit),
        .stack_lower_limit(stack_lower_limit),
        .overflow_pulse(ovf_pulse),
        .underflow_pulse(unf_pulse)
    );

    // ----------------------------------------------------------------
    // Events, flags and pending bits
    // ----------------------------------------------------------------
    logic [chtu_pkg::NSRC-1:0] evt;
    logic [chtu_pkg::NSRC-1:0] pend_q;
    logic [chtu_pkg::NSRC-1:0] pend_d;
    logic [chtu_pkg::NSRC-1:0] take_clr;
    logic [chtu_pkg::FLAG_W-1:0] flag_set;
    logic [chtu_pkg::FLAG_W-1:0] flag_q;
    logic [chtu_pkg::FLAG_W-1:0] flag_d;

    always_comb
    begin
        evt = '0;
        evt[chtu_pkg::SRC_REQ0] = sys_req0_trig;
        evt[chtu_pkg::SRC_OVF] = ovf_pulse;
        evt[chtu_pkg::SRC_UNF] = unf_pulse;
        evt[chtu_pkg::SRC_SBRK] = soft_break_trig;
        evt[chtu_pkg::SRC_REQ1] = sys_req1_trig;
        evt[chtu_pkg::SRC_UNDEF] = undef_opcode_trig;
        evt[chtu_pkg::SRC_ACCERR] = mem_access_err_trig;
        evt[chtu_pkg::SRC_PROT] = prot_instr_trig;
        evt[chtu_pkg::SRC_ILLWORD] = illegal_word_trig;
        flag_set = '0;
        flag_set[chtu_pkg::FLG_REQ0] = evt[chtu_pkg::SRC_REQ0];
        flag_set[chtu_pkg::FLG_OVF] = evt[chtu_pkg::SRC_OVF];
        flag_set[chtu_pkg::FLG_UNF] = evt[chtu_pkg::SRC_UNF];
        flag_set[chtu_pkg::FLG_SBRK] = evt[chtu_pkg::SRC_SBRK];
        flag_set[chtu_pkg::FLG_REQ1] = evt[chtu_pkg::SRC_REQ1];
        flag_set[chtu_pkg::FLG_UNDEF] = evt[chtu_pkg::SRC_UNDEF];
        flag_set[chtu_pkg::FLG_ACCERR] = evt[chtu_pkg::SRC_ACCERR];
        flag_set[chtu_pkg::FLG_PROT] = evt[chtu_pkg::SRC_PROT];
        flag_set[chtu_pkg::FLG_ILLWORD] = evt[chtu_pkg::SRC_ILLWORD];
        flag_d = (flag_q & ~trap_flag_clr) | flag_set;
        pend_d = (pend_q & ~take_clr) | evt;
    end

    // ----------------------------------------------------------------
    // Priority selection
    // ----------------------------------------------------------------
    logic sel_valid;
    logic [3:0] sel_idx;
    logic [1:0] sel_lvl;

    always_comb
    begin
        sel_valid = 1'b0;
        sel_idx = 4'h0;
        for (int i = chtu_pkg::NSRC - 1; i >= 0; i--)
        begin
            if (pend_q[i])
            begin
                sel_valid = 1'b1;
                sel_idx = 4'(i);
            end
        end
        sel_lvl = sel_valid ? lvl_of(sel_idx) : chtu_pkg::LVL_NONE;
    end

    // ----------------------------------------------------------------
    // Service state and nesting stack
    // ----------------------------------------------------------------
    chtu_pkg::chtu_state_e state_q;
    chtu_pkg::chtu_state_e state_d;
    logic [1:0] lvl_stk_q [0:2];
    logic [1:0] lvl_stk_d [0:2];
    logic [1:0] depth_q;
    logic [1:0] depth_d;
    logic [1:0] depth_eff;
    logic [1:0] cur_lvl;
    logic ret_ok;
    logic take;
    logic [6:0] num_q;
    logic [6:0] num_d;
    logic [chtu_pkg::SEG_W+chtu_pkg::ADDR_W-1:0] vec_q;
    logic [chtu_pkg::SEG_W+chtu_pkg::ADDR_W-1:0] vec_d;
    logic [chtu_pkg::ADDR_W-1:0] vec_off;
    typedef logic [chtu_pkg::ADDR_W-1:0] chtu_addr_t;

    always_comb
    begin
        ret_ok = trap_return && (state_q == chtu_pkg::CHTU_SERVICE) && (depth_q != 2'h0);
        depth_eff = ret_ok ? depth_q - 2'h1 : depth_q;
        cur_lvl = (depth_eff == 2'h0) ? chtu_pkg::LVL_NONE : lvl_stk_q[depth_eff - 2'h1];
        take = sel_valid && (state_q != chtu_pkg::CHTU_TAKE) && (sel_lvl > cur_lvl);
        take_clr = '0;
        if (take)
        begin
            if (sel_idx >= 4'(chtu_pkg::SRC_REQ1))
            begin
                take_clr[chtu_pkg::NSRC-1:chtu_pkg::SRC_REQ1] = '1;
            end
            else
            begin
                take_clr[sel_idx] = 1'b1;
            end
        end
        vec_off = chtu_addr_t'({9'h000, num_of(sel_idx)} << (3'h2 + {1'b0, vector_spacing_field}));
        state_d = state_q;
        depth_d = depth_eff;
        lvl_stk_d = lvl_stk_q;
        num_d = num_q;
        vec_d = vec_q;
        if (take)
        begin
            lvl_stk_d[depth_eff] = sel_lvl;
            depth_d = depth_eff + 2'h1;
            num_d = num_of(sel_idx);
            vec_d = {vector_segment_reg, vec_off};
        end
        case (state_q)
            chtu_pkg::CHTU_IDLE:
            begin
                if (take)
                begin
                    state_d = chtu_pkg::CHTU_TAKE;
                end
            end
            chtu_pkg::CHTU_TAKE:
            begin
                state_d = chtu_pkg::CHTU_SERVICE;
            end
            chtu_pkg::CHTU_SERVICE:
            begin
                if (take)
                begin
                    state_d = chtu_pkg::CHTU_TAKE;
                end
                else if (depth_eff == 2'h0)
                begin
                    state_d = chtu_pkg::CHTU_IDLE;
                end
            end
            default:
            begin
                state_d = chtu_pkg::CHTU_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            state_q <= chtu_pkg::CHTU_IDLE;
            depth_q <= 2'h0;
            lvl_stk_q <= '{2'h0, 2'h0, 2'h0};
            num_q <= 7'h00;
            vec_q <= '0;
            flag_q <= chtu_pkg::FLAG_RST;
            pend_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            depth_q <= depth_d;
            lvl_stk_q <= lvl_stk_d;
            num_q <= num_d;
            vec_q <= vec_d;
            flag_q <= flag_d;
            pend_q <= pend_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign trap_flag_reg = flag_q;
    assign trap_branch = (state_q == chtu_pkg::CHTU_TAKE);
    assign trap_vector_addr = vec_q;
    assign trap_number = num_q;
    assign trap_active = (depth_q != 2'h0);
    assign trap_level = (depth_q == 2'h0) ? chtu_pkg::LVL_NONE : lvl_stk_q[depth_q - 2'h1];
    assign intr_block = (depth_q != 2'h0);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_req0_vector: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sys_req0_trig && !trap_active && (state_q == chtu_pkg::CHTU_IDLE)
        && vector_spacing_field == 2'h0 |=> ##1 trap_branch
        && trap_vector_addr[chtu_pkg::ADDR_W-1:0] == 16'h0008 && trap_number == 7'h02)
        else $error("Request 0 vector wrong");
    a_classb_vec: assert property (@(posedge sys_clk) disable iff (!rst_n)
        trap_branch && trap_number == 7'h0a && vector_spacing_field == 2'h0
        |-> trap_vector_addr[chtu_pkg::ADDR_W-1:0] == 16'h0028)
        else $error("Class B vector wrong");
    a_seg_used: assert property (@(posedge sys_clk) disable iff (!rst_n)
        take |=> trap_vector_addr[chtu_pkg::SEG_W+chtu_pkg::ADDR_W-1:chtu_pkg::ADDR_W]
        == $past(vector_segment_reg))
        else $error("Vector segment not taken");
    a_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
        undef_opcode_trig |=> trap_flag_reg[chtu_pkg::FLG_UNDEF])
        else $error("Flag not set");
    a_flag_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
        trap_flag_reg[chtu_pkg::FLG_REQ0] && !trap_flag_clr[chtu_pkg::FLG_REQ0]
        |=> trap_flag_reg[chtu_pkg::FLG_REQ0])
        else $error("Flag dropped without clear");
    a_no_preempt: assert property (@(posedge sys_clk) disable iff (!rst_n)
        trap_level == chtu_pkg::LVL_REQ0 && !trap_return |=> !trap_branch)
        else $error("Preempted by lower trap");
    a_take_fast: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sys_req0_trig && trap_level != chtu_pkg::LVL_REQ0 |-> ##[1:3] trap_branch)
        else $error("Trap not taken promptly");
    a_block_irq: assert property (@(posedge sys_clk) disable iff (!rst_n)
        trap_branch |-> intr_block ##1 intr_block)
        else $error("Interrupts not blocked");
    a_stk_trap: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ovf_pulse |=> trap_flag_reg[chtu_pkg::FLG_OVF])
        else $error("Overflow flag missing");

    c_nested: cover property (@(posedge sys_clk) disable iff (!rst_n)
        trap_branch ##[1:10] (trap_branch && depth_q == 2'h2));
    c_classb: cover property (@(posedge sys_clk) disable iff (!rst_n)
        trap_branch && trap_number == chtu_pkg::NUM_CLASSB);
    c_return: cover property (@(posedge sys_clk) disable iff (!rst_n)
        trap_active ##1 !trap_active);

endmodule : chtu_trap_unit

// ### sim/chtu_pipe_model.sv
// Purpose: Pipeline-side partner that ends trap services.
// Assumes: Drives its output at the falling edge, like the bench.
// Notes: Ends the innermost service svc_len+1 cycles after a branch or return.
module chtu_pipe_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic trap_branch,
    input wire logic trap_active,
    input wire logic [15:0] svc_len,
    output logic trap_return,
    output int branch_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    initial
    begin
        trap_return = 1'b0;
        cnt = 0;
        branch_cnt = 0;
    end
    // ----------------------------------------------------------------
    // Service length and return pulse
    // ----------------------------------------------------------------
    always @(negedge sys_clk)
    begin
        trap_return <= 1'b0;
        if (!rst_n || trap_active !== 1'b1 || trap_branch === 1'b1)
            cnt <= 0;
        else if (cnt == svc_len)
        begin
            trap_return <= 1'b1;
            cnt <= 0;
        end
        else
            cnt <= cnt + 1;
    end
    always @(posedge sys_clk)
        if (rst_n && trap_branch === 1'b1)
            branch_cnt <= branch_cnt + 1;
endmodule : chtu_pipe_model

// ### sim/tb_top.sv
// Purpose: Self-checking bench of the hardware trap unit.
// Assumes: Inputs change at the falling edge; partner ends services.
// Notes: Trigger bits: req0, sbrk, req1, undef, acc, prot, illw.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [6:0] trig = 7'h00;
    logic stack_access = 1'b0;
    logic [15:0] stack_ptr = 16'h8000;
    logic [15:0] upper = 16'h0002;
    logic [15:0] lower = 16'hfffe;
    logic [7:0] seg = 8'h5a;
    logic [1:0] spc = 2'h0;
    logic [15:0] clr = 16'h0000;
    logic [15:0] svc_len = 16'h0008;
    logic [15:0] flags;
    logic trap_branch, trap_active, blk, trap_return;
    logic [23:0] vec;
    logic [6:0] num;
    logic [1:0] level;
    int branch_cnt, error_cnt = 0, samples_checked = 0, cyc = 0;
    always #5 sys_clk = ~sys_clk;
    chtu_trap_unit dut (.sys_clk(sys_clk), .rst_n(rst_n), .sys_req0_trig(trig[0]),
        .soft_break_trig(trig[1]), .sys_req1_trig(trig[2]), .undef_opcode_trig(trig[3]),
        .mem_access_err_trig(trig[4]), .prot_instr_trig(trig[5]),
        .illegal_word_trig(trig[6]), .stack_access(stack_access), .stack_ptr(stack_ptr),
        .stack_upper_limit(upper), .stack_lower_limit(lower), .vector_segment_reg(seg),
        .vector_spacing_field(spc), .trap_flag_clr(clr), .trap_return(trap_return),
        .trap_flag_reg(flags), .trap_branch(trap_branch), .trap_vector_addr(vec),
        .trap_number(num), .trap_active(trap_active), .trap_level(level), .intr_block(blk));
    chtu_pipe_model pipe (.sys_clk(sys_clk), .rst_n(rst_n), .trap_branch(trap_branch),
        .trap_active(trap_active), .svc_len(svc_len), .trap_return(trap_return),
        .branch_cnt(branch_cnt));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic pulse(input logic [6:0] t);
        @(negedge sys_clk) trig = t;
        @(negedge sys_clk) trig = 7'h00;
    endtask : pulse
    task automatic chk_take(input logic [6:0] n, input logic [1:0] lvl);
        logic [15:0] off;
        off = {9'h000, n} << (2 + spc);
        chk("branch", trap_branch, 1'b1);
        chk("vector", vec, {seg, off});
        chk("number", num, n);
        chk("active", trap_active, 1'b1);
        chk("level", level, lvl);
        chk("block", blk, 1'b1);
    endtask : chk_take
    task automatic wait_idle();
        for (int i = 0; i < 300 && trap_active !== 1'b0; i++)
            @(posedge sys_clk) #1;
        chk("block idle", blk, 1'b0);
    endtask : wait_idle
    task automatic clr_flags();
        @(negedge sys_clk) clr = 16'hffff;
        @(negedge sys_clk) clr = 16'h0000;
        chk("flags cleared", flags, 16'h0000);
    endtask : clr_flags
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_class_a();
        logic [6:0] tv [2] = '{7'h01, 7'h02};
        logic [15:0] fv [2] = '{16'h8000, 16'h1000};
        logic [6:0] nv [2] = '{7'h02, 7'h08};
        logic [1:0] lv [2] = '{2'h3, 2'h1};
        chk("reset flags", flags, 16'h0000);
        chk("reset active", trap_active, 1'b0);
        for (int i = 0; i < 2; i++)
        begin
            pulse(tv[i]);
            chk("flag", flags, fv[i]);
            @(posedge sys_clk) #1;
            chk_take(nv[i], lv[i]);
            @(posedge sys_clk) #1;
            chk("branch end", trap_branch, 1'b0);
            wait_idle();
            chk("sticky", flags, fv[i]);
            clr_flags();
        end
        $display("test class_a done");
    endtask : t_class_a
    task automatic stk(input logic [15:0] p, input logic [15:0] f, input logic [6:0] n);
        @(negedge sys_clk) stack_ptr = p;
        stack_access = 1'b1;
        @(negedge sys_clk) stack_access = 1'b0;
        @(posedge sys_clk) #1;
        chk("stack flag", flags, f);
        @(posedge sys_clk) #1;
        chk("stack branch", trap_branch, n != 7'h00);
        if (n != 7'h00)
            chk_take(n, 2'h2);
        wait_idle();
        clr_flags();
    endtask : stk
    task automatic t_stack();
        stk(16'h0002, 16'h0000, 7'h00);
        stk(16'hfffe, 16'h0000, 7'h00);
        stk(16'h0000, 16'h4000, 7'h04);
        stk(16'hffff, 16'h2000, 7'h06);
        $display("test stack done");
    endtask : t_stack
    task automatic t_class_b();
        logic [15:0] fv [5] = '{16'h0080, 16'h0008, 16'h0004, 16'h0002, 16'h0001};
        int b;
        for (int i = 0; i < 5; i++)
        begin
            pulse(7'h04 << i);
            chk("b flag", flags, fv[i]);
            @(posedge sys_clk) #1;
            chk_take(7'h0a, 2'h1);
            wait_idle();
            clr_flags();
        end
        b = branch_cnt;
        pulse(7'h7c);
        chk("all b flags", flags, 16'h008f);
        @(posedge sys_clk) #1;
        chk_take(7'h0a, 2'h1);
        wait_idle();
        chk("one b branch", branch_cnt - b, 1);
        clr_flags();
        $display("test class_b done");
    endtask : t_class_b
    task automatic t_spacing();
        for (int f = 1; f < 4; f++)
        begin
            @(negedge sys_clk) spc = f[1:0];
            pulse(7'h01);
            @(posedge sys_clk) #1;
            chk_take(7'h02, 2'h3);
            wait_idle();
            clr_flags();
        end
        @(negedge sys_clk) spc = 2'h0;
        $display("test spacing done");
    endtask : t_spacing
    task automatic t_prio();
        int b;
        svc_len = 16'h0028;
        pulse(7'h02);
        @(posedge sys_clk) #1;
        chk_take(7'h08, 2'h1);
        repeat (3) @(posedge sys_clk);
        b = branch_cnt;
        pulse(7'h02);
        repeat (4) @(posedge sys_clk);
        chk("equal level waits", branch_cnt - b, 0);
        pulse(7'h01);
        @(posedge sys_clk) #1;
        chk_take(7'h02, 2'h3);
        @(posedge sys_clk) #1;
        for (int i = 0; i < 200 && trap_branch !== 1'b1; i++)
            @(posedge sys_clk) #1;
        chk_take(7'h08, 2'h1);
        wait_idle();
        chk("sticky flags", flags, 16'h9000);
        clr_flags();
        $display("test priority done");
    endtask : t_prio
    // ----------------------------------------------------------------
    // Main sequence and timeout
    // ----------------------------------------------------------------
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            test_done();
        end
    end
    initial
    begin
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk) rst_n = 1'b1;
        t_class_a();
        t_stack();
        t_class_b();
        t_spacing();
        t_prio();
        test_done();
    end
endmodule : tb_top
